// *** verilog/swl_dev.sv ***
// single wire sensor device end: signaling and function commands
// Rules of the link this block works to
// - recall b8h loads thresholds into bytes 2,3
// - read slots show 0 busy, 1 done
// - recall runs by itself after reset
// - after b4h line-powered device pulls slot low
// - after beh send nine bytes, reset aborts
// - master writes exactly two bytes after 4eh
// - master holds strong pullup during 44h/48h
// - master reset pulse at least 480 us
// - presence after 15-60 us, 60-240 us long
// - master write slots at least 60 us
// - write one releases early, zero holds
// - sample write slot 15-60 us after fall
// - master read slot low then release
// - send zero by pulling low, release before end
// - read data valid 15 us after fall
// - master samples late in valid period
// - master reads after beh, b4h, 44h, b8h
// - one bit per time slot
// - master starts all slots except presence
// - bytes travel least significant bit first
// - low over 480 us resets transaction
// - line idles high through pullup
`timescale 1ns/10ps
module swl_dev #(
  parameter int US_DIV = swl_pkg::US_DIV,
  parameter int RECALL_US = swl_pkg::RECALL_US,
  parameter int CONV_US = swl_pkg::CONV_US
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // line side
  swl_if.dev bus,
  // user side
  input wire logic parasite_i,
  input wire logic [7:0] temp_lsb_i,
  input wire logic [7:0] temp_msb_i,
  input wire logic [7:0] crc_i,
  output logic [7:0] th_o,
  output logic [7:0] tl_o,
  output logic busy_o
);
  typedef enum logic [2:0] {S_IDLE, S_PWAIT, S_PRES, S_CMD, S_TX, S_RX, S_STAT} swl_dstate_t;
  swl_dstate_t st_q;
  logic [7:0] div_q;
  logic us_tick;
  logic sync1_q, sync2_q, prev_q;
  logic fall, rise;
  logic [9:0] low_us_q, slot_us_q, pt_us_q;
  logic in_slot_q, sampled_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic [3:0] byte_q;
  logic drive_q;
  logic [7:0] nv_th_q, nv_tl_q, th_q, tl_q;
  logic [7:0] cmd_q;
  logic [11:0] op_us_q;
  logic recall_q, conv_q;
  logic byte_done;
  logic [7:0] tx_byte;

  // microsecond enable
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      div_q <= 8'h00;
    else if (us_tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  assign us_tick = (div_q == 8'(US_DIV - 1));

  // line synchroniser and edge detect
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else
    begin
      sync1_q <= bus.line;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  assign fall = prev_q & ~sync2_q;
  assign rise = ~prev_q & sync2_q;

  // low-time and slot timers
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      low_us_q <= '0;
      slot_us_q <= '0;
      in_slot_q <= 1'b0;
    end
    else
    begin
      if (sync2_q)
        low_us_q <= '0;
      else if (us_tick && low_us_q != 10'h3ff)
        low_us_q <= low_us_q + 10'h001;
      if (fall && st_q != S_PRES)
      begin
        slot_us_q <= '0;
        in_slot_q <= 1'b1;
      end
      else if (in_slot_q && us_tick)
      begin
        slot_us_q <= slot_us_q + 10'h001;
        if (slot_us_q == 10'(swl_pkg::SAMPLE_US))
          in_slot_q <= 1'b0;
      end
    end

  // current transmit byte, lsb first
  always_comb
  begin
    tx_byte = 8'h00;
    unique case (byte_q)
      4'h0: tx_byte = temp_lsb_i;
      4'h1: tx_byte = temp_msb_i;
      4'h2: tx_byte = th_q;
      4'h3: tx_byte = tl_q;
      4'h4: tx_byte = 8'hff;
      4'h5: tx_byte = 8'hff;
      4'h6: tx_byte = 8'h0c;
      4'h7: tx_byte = 8'h10;
      default: tx_byte = crc_i;
    endcase
  end
  assign byte_done = (bit_q == 3'h7);

  // main sequencer
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      st_q <= S_IDLE;
      pt_us_q <= '0;
      sh_q <= '0;
      bit_q <= '0;
      byte_q <= '0;
      cmd_q <= '0;
      drive_q <= 1'b0;
      sampled_q <= 1'b0;
    end
    else if (rise && low_us_q >= 10'(swl_pkg::RESET_MIN_US))
    begin
      st_q <= S_PWAIT;
      pt_us_q <= '0;
      bit_q <= '0;
      byte_q <= '0;
      drive_q <= 1'b0;
    end
    else
    begin
      if (fall)
        sampled_q <= 1'b0;
      unique case (st_q)
        S_IDLE: drive_q <= 1'b0;
        S_PWAIT:
          if (us_tick)
          begin
            pt_us_q <= pt_us_q + 10'h001;
            if (pt_us_q == 10'(swl_pkg::PRES_WAIT_US))
            begin
              st_q <= S_PRES;
              pt_us_q <= '0;
              drive_q <= 1'b1;
            end
          end
        S_PRES:
          if (us_tick)
          begin
            pt_us_q <= pt_us_q + 10'h001;
            if (pt_us_q == 10'(swl_pkg::PRES_LEN_US))
            begin
              drive_q <= 1'b0;
              st_q <= S_CMD;
            end
          end
        S_CMD, S_RX:
          if (in_slot_q && !sampled_q && us_tick && slot_us_q == 10'(swl_pkg::SAMPLE_US))
          begin
            sampled_q <= 1'b1;
            sh_q <= {sync2_q, sh_q[7:1]};
            bit_q <= bit_q + 3'h1;
            if (byte_done && st_q == S_CMD)
            begin
              cmd_q <= {sync2_q, sh_q[7:1]};
              byte_q <= '0;
              unique case ({sync2_q, sh_q[7:1]})
                swl_pkg::CMD_READ_SP: st_q <= S_TX;
                swl_pkg::CMD_WRITE_SP: st_q <= S_RX;
                swl_pkg::CMD_POWER, swl_pkg::CMD_RECALL, swl_pkg::CMD_CONVERT: st_q <= S_STAT;
                default: st_q <= S_IDLE;
              endcase
            end
            else if (byte_done)
            begin
              byte_q <= byte_q + 4'h1;
              if (byte_q == 4'h1)
                st_q <= S_IDLE;
            end
          end
        S_TX:
          if (fall)
            drive_q <= ~tx_byte[bit_q];
          else if (in_slot_q && us_tick && slot_us_q == 10'(swl_pkg::READ_HOLD_US))
          begin
            drive_q <= 1'b0;
            bit_q <= bit_q + 3'h1;
            if (byte_done)
            begin
              byte_q <= byte_q + 4'h1;
              if (byte_q == 4'(swl_pkg::SP_BYTES - 1))
                st_q <= S_IDLE;
            end
          end
        S_STAT:
          if (fall)
          begin
            if (cmd_q == swl_pkg::CMD_POWER)
              drive_q <= parasite_i;
            else
              drive_q <= busy_o;
          end
          else if (in_slot_q && us_tick && slot_us_q == 10'(swl_pkg::READ_HOLD_US))
          begin
            drive_q <= 1'b0;
            if (cmd_q == swl_pkg::CMD_POWER)
              st_q <= S_IDLE;
          end
        default: st_q <= S_IDLE;
      endcase
    end

  // threshold store, recall, conversion and copy
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      nv_th_q <= swl_pkg::NV_TH_RST;
      nv_tl_q <= swl_pkg::NV_TL_RST;
      th_q <= 8'h00;
      tl_q <= 8'h00;
      recall_q <= 1'b1;
      conv_q <= 1'b0;
      op_us_q <= '0;
    end
    else
    begin
      if (recall_q && us_tick)
      begin
        op_us_q <= op_us_q + 12'h001;
        if (op_us_q == 12'(RECALL_US))
        begin
          recall_q <= 1'b0;
          th_q <= nv_th_q;
          tl_q <= nv_tl_q;
        end
      end
      else if (conv_q && us_tick)
      begin
        op_us_q <= op_us_q + 12'h001;
        if (op_us_q == 12'(CONV_US))
          conv_q <= 1'b0;
      end
      if (st_q == S_CMD && in_slot_q && !sampled_q && us_tick && byte_done
          && slot_us_q == 10'(swl_pkg::SAMPLE_US))
      begin
        op_us_q <= '0;
        unique case ({sync2_q, sh_q[7:1]})
          swl_pkg::CMD_RECALL: recall_q <= 1'b1;
          swl_pkg::CMD_CONVERT: conv_q <= 1'b1;
          swl_pkg::CMD_COPY:
          begin
            nv_th_q <= th_q;
            nv_tl_q <= tl_q;
          end
          default: op_us_q <= op_us_q;
        endcase
      end
      if (st_q == S_RX && in_slot_q && !sampled_q && us_tick && byte_done
          && slot_us_q == 10'(swl_pkg::SAMPLE_US))
      begin
        if (byte_q == 4'h0)
          th_q <= {sync2_q, sh_q[7:1]};
        else
          tl_q <= {sync2_q, sh_q[7:1]};
      end
    end

  // outputs
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      bus.dev_oe_b <= 1'b1;
      th_o <= 8'h00;
      tl_o <= 8'h00;
      busy_o <= 1'b1;
    end
    else
    begin
      bus.dev_oe_b <= ~drive_q;
      th_o <= th_q;
      tl_o <= tl_q;
      busy_o <= recall_q | conv_q | (recall_q & us_tick);
    end
endmodule

// *** verilog/swl_pkg.sv ***
// shared constants for the single wire sensor link
package swl_pkg;
  localparam int CLK_MHZ = 200;
  // microsecond tick divider
  localparam int US_DIV = CLK_MHZ;
  // times in microseconds
  localparam int RESET_MIN_US = 480;
  localparam int PRES_WAIT_US = 30;
  localparam int PRES_LEN_US = 120;
  localparam int SAMPLE_US = 30;
  localparam int READ_HOLD_US = 15;
  localparam int SLOT_US = 70;
  localparam int INIT_LOW_US = 2;
  localparam int MSAMPLE_US = 12;
  localparam int RECOVER_US = 2;
  localparam int RESET_TX_US = 500;
  localparam int PRES_WINDOW_US = 300;
  localparam int RECALL_US = 20;
  localparam int CONV_US = 1000;
  // function command codes
  localparam logic [7:0] CMD_RECALL = 8'hb8;
  localparam logic [7:0] CMD_POWER = 8'hb4;
  localparam logic [7:0] CMD_READ_SP = 8'hbe;
  localparam logic [7:0] CMD_WRITE_SP = 8'h4e;
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_COPY = 8'h48;
  // scratchpad layout
  localparam int SP_BYTES = 9;
  localparam int SP_TH = 2;
  localparam int SP_TL = 3;
  localparam logic [7:0] NV_TH_RST = 8'h4b;
  localparam logic [7:0] NV_TL_RST = 8'h46;
  // master operations
  localparam logic [1:0] OP_RESET = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_PULLUP = 2'h3;
endpackage

// *** verilog/swl_if.sv ***
// line carrier joining device and master
`timescale 1ns/10ps
interface swl_if;
  logic dev_oe_b;
  logic mst_oe_b;
  logic mst_spu;
  logic line;
  // wired and with pullup: any low enable pulls the line low
  assign line = dev_oe_b & mst_oe_b;
  modport dev (input line, output dev_oe_b);
  modport mst (input line, output mst_oe_b, output mst_spu);
endinterface

// *** verilog/swl_mst.sv ***
// single wire master end: times every slot
`timescale 1ns/10ps
module swl_mst #(
  parameter int US_DIV = swl_pkg::US_DIV
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // line side
  swl_if.mst bus,
  // user request
  input wire logic req_i,
  input wire logic [1:0] op_i,
  input wire logic wbit_i,
  input wire logic [11:0] pullup_us_i,
  // user answer
  output logic ready_o,
  output logic done_o,
  output logic rbit_o,
  output logic presence_o
);
  typedef enum logic [1:0] {M_IDLE, M_RUN} swl_mstate_t;
  swl_mstate_t st_q;
  logic [7:0] div_q;
  logic us_tick;
  logic [11:0] t_q;
  logic [1:0] op_q;
  logic wb_q, seen_q;
  logic [11:0] end_us;

  // microsecond enable
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      div_q <= 8'h00;
    else if (us_tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  assign us_tick = (div_q == 8'(US_DIV - 1));

  // length of each operation; read and write slots include recovery
  always_comb
  begin
    end_us = 12'(swl_pkg::SLOT_US + swl_pkg::RECOVER_US);
    unique case (op_q)
      swl_pkg::OP_RESET: end_us = 12'(swl_pkg::RESET_TX_US + swl_pkg::PRES_WINDOW_US);
      swl_pkg::OP_PULLUP: end_us = pullup_us_i;
      default: end_us = 12'(swl_pkg::SLOT_US + swl_pkg::RECOVER_US);
    endcase
  end

  // slot sequencer and line drive
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      st_q <= M_IDLE;
      t_q <= '0;
      op_q <= swl_pkg::OP_RESET;
      wb_q <= 1'b0;
      seen_q <= 1'b0;
      bus.mst_oe_b <= 1'b1;
      bus.mst_spu <= 1'b0;
      ready_o <= 1'b0;
      done_o <= 1'b0;
      rbit_o <= 1'b0;
      presence_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      unique case (st_q)
        M_IDLE:
        begin
          ready_o <= 1'b1;
          if (req_i && ready_o)
          begin
            st_q <= M_RUN;
            ready_o <= 1'b0;
            op_q <= op_i;
            wb_q <= wbit_i;
            t_q <= '0;
            seen_q <= 1'b0;
            bus.mst_oe_b <= (op_i == swl_pkg::OP_PULLUP);
            bus.mst_spu <= (op_i == swl_pkg::OP_PULLUP);
          end
        end
        M_RUN:
          if (us_tick)
          begin
            t_q <= t_q + 12'h001;
            unique case (op_q)
              swl_pkg::OP_RESET:
              begin
                if (t_q == 12'(swl_pkg::RESET_TX_US))
                  bus.mst_oe_b <= 1'b1;
                if (t_q > 12'(swl_pkg::RESET_TX_US) && !bus.line)
                  seen_q <= 1'b1;
              end
              swl_pkg::OP_WRITE:
                if ((wb_q && t_q == 12'(swl_pkg::INIT_LOW_US)) || t_q == 12'(swl_pkg::SLOT_US))
                  bus.mst_oe_b <= 1'b1;
              swl_pkg::OP_READ:
              begin
                if (t_q == 12'(swl_pkg::INIT_LOW_US))
                  bus.mst_oe_b <= 1'b1;
                if (t_q == 12'(swl_pkg::MSAMPLE_US))
                  rbit_o <= bus.line;
              end
              default: bus.mst_oe_b <= 1'b1;
            endcase
            if (t_q == end_us)
            begin
              st_q <= M_IDLE;
              bus.mst_spu <= 1'b0;
              bus.mst_oe_b <= 1'b1;
              done_o <= 1'b1;
              if (op_q == swl_pkg::OP_RESET)
                presence_o <= seen_q;
            end
          end
        default: st_q <= M_IDLE;
      endcase
    end
endmodule

// *** tb/swl_link_properties.sv ***
// wire-level checks for the single wire link
`timescale 1ns/10ps
module swl_link_props #(
  parameter int US_DIV = 200
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // line signals
  input wire logic dev_oe_b,
  input wire logic mst_oe_b,
  input wire logic mst_spu,
  input wire logic line
);
  localparam logic [19:0] T1 = 20'(US_DIV);
  localparam logic [19:0] T15 = 20'(15 * US_DIV);
  localparam logic [19:0] T60 = 20'(60 * US_DIV);
  localparam logic [19:0] T240 = 20'(240 * US_DIV);
  localparam logic [19:0] T480 = 20'(480 * US_DIV);
  logic line_q;
  logic [19:0] low_cnt_q;
  logic [19:0] fall_cnt_q;
  logic [19:0] rise_cnt_q;
  logic [19:0] dlow_cnt_q;
  logic [19:0] mlow_cnt_q;
  logic [19:0] mhigh_cnt_q;
  logic pres_arm_q;
  logic dev_self_q;

  // saturating count, so long idle spans never wrap
  function automatic logic [19:0] sat(input logic [19:0] v);
    sat = (v == 20'hfffff) ? v : v + 20'h00001;
  endfunction

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // line low length, time since line fall and rise
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      line_q <= 1'b1;
      low_cnt_q <= 20'h00000;
      fall_cnt_q <= 20'hfffff;
      rise_cnt_q <= 20'hfffff;
    end
    else
    begin
      line_q <= line;
      low_cnt_q <= line ? 20'h00000 : sat(low_cnt_q);
      fall_cnt_q <= (line_q && !line) ? 20'h00000 : sat(fall_cnt_q);
      rise_cnt_q <= (!line_q && line) ? 20'h00000 : sat(rise_cnt_q);
    end
  end

  // master drive lengths, high span preset so the first slot is legal
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mlow_cnt_q <= 20'h00000;
      mhigh_cnt_q <= 20'hfffff;
    end
    else
    begin
      mlow_cnt_q <= mst_oe_b ? 20'h00000 : sat(mlow_cnt_q);
      mhigh_cnt_q <= mst_oe_b ? sat(mhigh_cnt_q) : 20'h00000;
    end
  end

  // device drive length, presence armed by a long low, own-start flag
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dlow_cnt_q <= 20'h00000;
      pres_arm_q <= 1'b0;
      dev_self_q <= 1'b0;
    end
    else
    begin
      dlow_cnt_q <= dev_oe_b ? 20'h00000 : sat(dlow_cnt_q);
      if (!line_q && line && low_cnt_q >= T480)
        pres_arm_q <= 1'b1;
      else if (!dev_oe_b || rise_cnt_q > T60)
        pres_arm_q <= 1'b0;
      if (!dev_oe_b && dlow_cnt_q == 20'h00000)
        dev_self_q <= mst_oe_b;
    end
  end

  chk_pres_window: assert property ($fell(dev_oe_b) && mst_oe_b |-> pres_arm_q && rise_cnt_q >= T15)
    else $error("presence began outside its window");
  chk_pres_late: assert property (pres_arm_q |-> rise_cnt_q <= T60)
    else $error("presence missing after reset");
  chk_pres_width: assert property ($rose(dev_oe_b) && dev_self_q |-> dlow_cnt_q >= T60 && dlow_cnt_q <= T240)
    else $error("presence width wrong");
  chk_read_start: assert property ($fell(dev_oe_b) && !mst_oe_b |-> fall_cnt_q < T15)
    else $error("read zero driven late");
  chk_read_hold: assert property ($rose(dev_oe_b) && !dev_self_q |-> fall_cnt_q >= T15 - 2 && fall_cnt_q < T60)
    else $error("read zero released out of window");
  chk_long_low: assert property (low_cnt_q >= T480 |-> dev_oe_b)
    else $error("device drives during reset");
  chk_pullup_quiet: assert property (mst_spu |-> mst_oe_b && dev_oe_b)
    else $error("traffic under strong pullup");
  chk_slot_shape: assert property ($rose(mst_oe_b) |-> mlow_cnt_q >= T1 && (mlow_cnt_q < T15 || mlow_cnt_q >= T60))
    else $error("master low pulse length wrong");
  chk_slot_space: assert property ($fell(mst_oe_b) |-> mhigh_cnt_q >= T1 && fall_cnt_q >= T60)
    else $error("master slot too short");

  cover property ($rose(dev_oe_b) && dev_self_q);
  cover property ($rose(dev_oe_b) && !dev_self_q);
  cover property ($rose(mst_spu));
endmodule

// *** tb/swl_tb.sv ***
// self-checking bench joining device and master ends
`timescale 1ns/10ps
module swl_tb;
  localparam int UD = 5;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic req_i = 1'b0;
  logic [1:0] op_i = 2'h0;
  logic wbit_i = 1'b0;
  logic [11:0] pullup_us_i = 12'h014;
  logic parasite_i = 1'b1;
  logic [7:0] temp_lsb_i = 8'h00;
  logic [7:0] temp_msb_i = 8'h00;
  logic [7:0] crc_i = 8'h00;
  logic [7:0] th_o;
  logic [7:0] tl_o;
  logic busy_o;
  logic ready_o;
  logic done_o;
  logic rbit_o;
  logic presence_o;
  logic [7:0] lfsr_q = 8'h3a;
  logic [7:0] th_v;
  logic [7:0] tl_v;
  logic [3:0] note_v;
  logic [3:0] note_q[$];
  int err_count = 0;
  int checked = 0;

  swl_if bus_if();
  swl_dev #(.US_DIV(UD), .RECALL_US(100), .CONV_US(50)) i_swl_dev (.sys_clk_i, .rst_b_i, .bus(bus_if),
    .parasite_i, .temp_lsb_i, .temp_msb_i, .crc_i, .th_o, .tl_o, .busy_o);
  swl_mst #(.US_DIV(UD)) i_swl_mst (.sys_clk_i, .rst_b_i, .bus(bus_if), .req_i, .op_i, .wbit_i,
    .pullup_us_i, .ready_o, .done_o, .rbit_o, .presence_o);
  swl_link_props #(.US_DIV(UD)) i_swl_link_props (.sys_clk_i, .rst_b_i, .dev_oe_b(bus_if.dev_oe_b),
    .mst_oe_b(bus_if.mst_oe_b), .mst_spu(bus_if.mst_spu), .line(bus_if.line));

  // 200 MHz clock
  initial
  begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one master operation; note holds {care, expected bit}
  task automatic run_op(input logic [1:0] op, input logic wb, input logic [1:0] note);
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    note_q.push_back({op, note});
    req_i <= 1'b1;
    op_i <= op;
    wbit_i <= wb;
    @(posedge sys_clk_i);
    req_i <= 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 20000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    @(posedge sys_clk_i);
  endtask

  task automatic wr_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      run_op(swl_pkg::OP_WRITE, b[i], 2'b00);
  endtask

  task automatic rd_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      run_op(swl_pkg::OP_READ, 1'b1, {1'b1, b[i]});
  endtask

  task automatic tally_and_finish;
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // result watcher: oldest note against each completed operation
  always @(posedge sys_clk_i)
  begin
    if (done_o === 1'b1 && note_q.size() > 0)
    begin
      note_v = note_q.pop_front();
      if (note_v[1])
        chk_bit(note_v[3:2] == swl_pkg::OP_RESET ? "presence" : "rbit", note_v[0],
          note_v[3:2] == swl_pkg::OP_RESET ? presence_o : rbit_o);
    end
  end

  // hang guard
  initial
  begin
    repeat (75000) @(posedge sys_clk_i);
    err_count++;
    tally_and_finish;
  end

  // main sequence
  initial
  begin
    int n;
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    lfsr_q = lfsr_next(lfsr_q);
    temp_lsb_i <= lfsr_q;
    lfsr_q = lfsr_next(lfsr_q);
    temp_msb_i <= lfsr_q;
    crc_i <= ~lfsr_q;
    lfsr_q = lfsr_next(lfsr_q);
    th_v = lfsr_q;
    lfsr_q = lfsr_next(lfsr_q);
    tl_v = lfsr_q;
    repeat (2) @(posedge sys_clk_i);
    n = 0;
    while (busy_o !== 1'b0 && n < 5000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    chk_byte("th", swl_pkg::NV_TH_RST, th_o);
    chk_byte("tl", swl_pkg::NV_TL_RST, tl_o);
    // threshold write, then abort a scratchpad read
    run_op(swl_pkg::OP_RESET, 1'b1, 2'b11);
    wr_byte(swl_pkg::CMD_WRITE_SP);
    wr_byte(th_v);
    wr_byte(tl_v);
    run_op(swl_pkg::OP_RESET, 1'b1, 2'b11);
    chk_byte("th", th_v, th_o);
    chk_byte("tl", tl_v, tl_o);
    wr_byte(swl_pkg::CMD_READ_SP);
    rd_byte(temp_lsb_i);
    rd_byte(temp_msb_i);
    rd_byte(th_v);
    run_op(swl_pkg::OP_RESET, 1'b1, 2'b11);
    // recall with status polling
    wr_byte(swl_pkg::CMD_RECALL);
    run_op(swl_pkg::OP_READ, 1'b1, 2'b10);
    run_op(swl_pkg::OP_READ, 1'b1, 2'b11);
    chk_byte("th", swl_pkg::NV_TH_RST, th_o);
    chk_byte("tl", swl_pkg::NV_TL_RST, tl_o);
    run_op(swl_pkg::OP_PULLUP, 1'b1, 2'b00);
    // supply mode report from a line-powered device
    run_op(swl_pkg::OP_RESET, 1'b1, 2'b11);
    wr_byte(swl_pkg::CMD_POWER);
    run_op(swl_pkg::OP_READ, 1'b1, 2'b10);
    // conversion held under strong pullup, then a done poll
    pullup_us_i <= 12'h03c;
    run_op(swl_pkg::OP_RESET, 1'b1, 2'b11);
    wr_byte(swl_pkg::CMD_CONVERT);
    chk_bit("busy", 1'b1, busy_o);
    run_op(swl_pkg::OP_PULLUP, 1'b1, 2'b00);
    chk_bit("busy", 1'b0, busy_o);
    run_op(swl_pkg::OP_READ, 1'b1, 2'b11);
    // supply mode report from an externally supplied device
    parasite_i <= 1'b0;
    run_op(swl_pkg::OP_RESET, 1'b1, 2'b11);
    wr_byte(swl_pkg::CMD_POWER);
    run_op(swl_pkg::OP_READ, 1'b1, 2'b11);
    tally_and_finish;
  end
endmodule
